// File: ks_contact_model.sv
/*
 * Contacts of a keyer, radio or footswitch on the two input jacks.
 * Assumes each pin is pulled high while its contact is open.
 */
`timescale 1ns/1ps

module ks_contact_model (
	// closures asked for by the bench
	input  wire logic [3:0] i_close,
	// contact pins
	output logic            o_jack_one_tip_input_n,
	output logic            o_jack_one_ring_input_n,
	output logic            o_jack_two_tip_input_n,
	output logic            o_jack_two_ring_input_n
);
	// a closure shorts the pin to return, an open pin sits at the pull-up
	assign o_jack_one_tip_input_n = !i_close[0];
	assign o_jack_one_ring_input_n = !i_close[1];
	assign o_jack_two_tip_input_n = !i_close[2];
	assign o_jack_two_ring_input_n = !i_close[3];
endmodule

// File: ks_delay_mem.sv
/*
 * Delay table: twenty 16-bit words, one write port and two read ports
 * whose data come out of registers one clock after the address.
 * Assumes the writer and the readers share i_core_clk.
 */
`timescale 1ns/1ps
`include "ks_params.svh"

module ks_delay_mem (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_nrst,
	// write port
	input  wire logic                     i_wr_en,
	input  wire logic [`KS_SLOT_W-1:0]    i_wr_addr,
	input  wire logic [`KS_DELAY_W-1:0]   i_wr_data,
	// read port a, sequencer
	input  wire logic [`KS_SLOT_W-1:0]    i_rd_a_addr,
	output logic      [`KS_DELAY_W-1:0]   o_rd_a_data,
	// read port b, bus
	input  wire logic [`KS_SLOT_W-1:0]    i_rd_b_addr,
	output logic      [`KS_DELAY_W-1:0]   o_rd_b_data
);

	logic [`KS_DELAY_W-1:0] mem [`KS_NUM_SLOTS];

	// ------------------------------------------------------------------
	// storage; cleared so every delay starts at zero
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < `KS_NUM_SLOTS; i++) begin
				mem[i] <= '0;
			end
		end else if (i_wr_en && (32'(i_wr_addr) < `KS_NUM_SLOTS)) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	// ------------------------------------------------------------------
	// registered reads; out-of-range slots read zero
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rd_a_data <= '0;
			o_rd_b_data <= '0;
		end else begin
			o_rd_a_data <= (32'(i_rd_a_addr) < `KS_NUM_SLOTS) ?
				mem[i_rd_a_addr] : '0;
			o_rd_b_data <= (32'(i_rd_b_addr) < `KS_NUM_SLOTS) ?
				mem[i_rd_b_addr] : '0;
		end
	end

endmodule

// File: ks_params.svh
/*
 * Constants of the keying output sequencer: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included by bare name wherever these names are used.
 */
`ifndef KS_PARAMS_SVH
`define KS_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define KS_CLK_PERIOD_NS   25
`define KS_TICK_NS         1000000
`define KS_TICK_CYCLES     (`KS_TICK_NS / `KS_CLK_PERIOD_NS)
`define KS_FAST_MAX_MS     16'h1FFF
`define KS_SLOW_MAX_MS     16'hFFFF

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define KS_NUM_CH          5
`define KS_LAST_CH         3'h4
`define KS_FIRST_CH        3'h0
`define KS_CW_SKIP_CH      3'h3
`define KS_PTT_SKIP_CH     3'h4
`define KS_NUM_SLOTS       20
`define KS_SET_STRIDE      5'h0A
`define KS_END_STRIDE      5'h05
`define KS_DELAY_W         16
`define KS_SLOT_W          5

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define KS_ADDR_W          8
`define KS_OFF_CTRL        8'h00
`define KS_OFF_STATUS      8'h04
`define KS_OFF_TABLE       8'h40
`define KS_OFF_TABLE_END   8'h8C

// ctrl fields and reset value
`define KS_CTRL_MODE_LO    0
`define KS_CTRL_MODE_HI    1
`define KS_CTRL_FAST       2
`define KS_CTRL_INV_LO     8
`define KS_CTRL_INV_HI     12
`define KS_CTRL_RESET      32'h0000_0004

// status fields
`define KS_ST_OUT_LO       0
`define KS_ST_OUT_HI       4
`define KS_ST_BUSY         8
`define KS_ST_PTT          9
`define KS_ST_END          10
`define KS_ST_IN_LO        12
`define KS_ST_IN_HI        15

`endif

// File: ks_pkg.sv
/*
 * Types of the keying output sequencer.
 * Assumes ks_params.svh is available on the include path.
 */
package ks_pkg;

	// ------------------------------------------------------------------
	// configurations
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		KS_MODE_CW_ONLY  = 2'h0,
		KS_MODE_COMBINED = 2'h1,
		KS_MODE_DUAL     = 2'h2
	} ks_mode_e;

	// ------------------------------------------------------------------
	// sequencer states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		KS_IDLE  = 5'h01,
		KS_LOOK  = 5'h02,
		KS_FETCH = 5'h04,
		KS_TIME  = 5'h08,
		KS_HOLD  = 5'h10
	} ks_state_e;

endpackage

// File: ks_seq_chk_sva.sv
/*
 * Port checker for the keying sequencer: bus handshake and channel steps.
 * Assumes ctrl is written only while the channels are idle.
 */
`timescale 1ns/1ps
`include "ks_params.svh"

module ks_seq_chk #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire logic        i_jack_one_tip_input_n,
	input wire logic        i_jack_one_ring_input_n,
	input wire logic        i_jack_two_tip_input_n,
	input wire logic        i_jack_two_ring_input_n,
	input wire logic [4:0]  o_channel_out
);
	logic [1:0] mode;
	logic [1:0] settle;
	logic [4:0] inv;
	logic [4:0] raw;
	logic [4:0] prev;
	logic [4:0] d;
	logic [2:0] open_cnt;
	logic       wr_ctrl;
	logic       mapped;
	logic       quiet;

	assign wr_ctrl = i_psel && i_penable && i_pwrite && o_pready
		&& i_paddr == `KS_OFF_CTRL;
	assign mapped = i_paddr == `KS_OFF_CTRL || i_paddr == `KS_OFF_STATUS
		|| (i_paddr >= `KS_OFF_TABLE && i_paddr <= `KS_OFF_TABLE_END);
	assign raw = o_channel_out ^ inv;
	assign d = raw ^ prev;
	assign quiet = settle == 2'h0;

	// pins may trail an inversion write, so steps are ignored meanwhile
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode <= 2'h0;
			inv <= 5'h00;
			settle <= 2'h0;
		end else if (wr_ctrl) begin
			mode <= i_pwdata[1:0];
			inv <= i_pwdata[12:8];
			settle <= 2'h3;
		end else if (!quiet) begin
			settle <= settle - 2'h1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev <= 5'h00;
			open_cnt <= 3'h0;
		end else begin
			prev <= raw;
			if (!(i_jack_one_tip_input_n && i_jack_one_ring_input_n
				&& i_jack_two_tip_input_n && i_jack_two_ring_input_n)) begin
				open_cnt <= 3'h0;
			end else if (open_cnt != 3'h7) begin
				open_cnt <= open_cnt + 3'h1;
			end
		end
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_acc_start;
		i_psel && $rose(i_penable);
	endsequence

	a_ready_wait: assert property (s_acc_start |-> !o_pready ##1 o_pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("pready outside access phase");
	a_err_map: assert property (o_pready && i_paddr[1:0] == 2'h0
		|-> o_pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_reset_open: assert property ($rose(i_nrst) |-> o_channel_out == 5'h00)
		else $error("channels not open after reset");
	a_one_step: assert property (quiet |-> $onehot0(d))
		else $error("more than one channel moved at once");
	a_top_bit: assert property (quiet && d != 5'h00
		|-> {1'b0, raw | prev} < {d, 1'b0})
		else $error("channel moved out of order");
	a_min_gap: assert property (quiet && d != 5'h00 |=> (d == 5'h00) [*2])
		else $error("channel steps too close");
	a_no_key_idle: assert property (open_cnt == 3'h7 && quiet
		&& prev == 5'h00 |-> raw == 5'h00)
		else $error("channel closed with no input");
	a_mode_excl: assert property (quiet && (mode == 2'h1 || mode == 2'h2)
		|-> !(raw[3] && raw[4]))
		else $error("channels four and five closed together");
endmodule

bind ks_sequencer ks_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_prdata(o_prdata), .i_jack_one_tip_input_n(i_jack_one_tip_input_n),
	.i_jack_one_ring_input_n(i_jack_one_ring_input_n),
	.i_jack_two_tip_input_n(i_jack_two_tip_input_n),
	.i_jack_two_ring_input_n(i_jack_two_ring_input_n),
	.o_channel_out(o_channel_out));

// File: ks_sequencer.sv
/*
 * Keying output sequencer: four contact inputs, five timed output
 * channels, configured over an APB slave.
 * Assumes contact inputs are asynchronous pins pulled high and pulled
 * low by a closure to the common return, and a 40 MHz core clock.
 */

`timescale 1ns/1ps
`include "ks_params.svh"

module ks_sequencer
	import ks_pkg::*;
#(
	parameter int TICK_CYCLES = `KS_TICK_CYCLES
) (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_nrst,
	// apb slave
	input  wire logic                     i_psel,
	input  wire logic                     i_penable,
	input  wire logic                     i_pwrite,
	input  wire logic [`KS_ADDR_W-1:0]    i_paddr,
	input  wire logic [31:0]              i_pwdata,
	output logic                          o_pready,
	output logic                          o_pslverr,
	output logic      [31:0]              o_prdata,
	// contact inputs, low while closed
	input  wire logic                     i_jack_one_tip_input_n,
	input  wire logic                     i_jack_one_ring_input_n,
	input  wire logic                     i_jack_two_tip_input_n,
	input  wire logic                     i_jack_two_ring_input_n,
	// output channels, high while the relay is closed unless its ctrl invert bit is set
	output logic      [`KS_NUM_CH-1:0]    o_channel_out
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [`KS_SLOT_W-1:0] slot_of(
		input logic       set_ptt,
		input logic       end_phase,
		input logic [2:0] ch
	);
		logic [`KS_SLOT_W-1:0] s;
		s = {2'h0, ch};
		if (set_ptt) begin
			s = s + `KS_SET_STRIDE;
		end
		if (end_phase) begin
			s = s + `KS_END_STRIDE;
		end
		return s;
	endfunction

	function automatic logic [`KS_DELAY_W-1:0] limit_delay(
		input logic [`KS_DELAY_W-1:0] d,
		input logic                   fast
	);
		logic [`KS_DELAY_W-1:0] lim;
		lim = fast ? `KS_FAST_MAX_MS : `KS_SLOW_MAX_MS;
		return (d > lim) ? lim : d;
	endfunction

	function automatic logic in_table(input logic [`KS_ADDR_W-1:0] a);
		return (a >= `KS_OFF_TABLE) && (a <= `KS_OFF_TABLE_END) &&
			(a[1:0] == 2'h0);
	endfunction

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [3:0]             in_sync1;
	logic [3:0]             in_sync2;
	logic [3:0]             in_active;
	logic                   cw_req;
	logic                   ptt_req;

	logic [31:0]            ctrl;
	ks_mode_e               mode;
	logic                   fast_clock_select;
	logic [`KS_NUM_CH-1:0]  invert;

	ks_state_e              state;
	logic                   seq_ptt;
	logic                   end_phase;
	logic [2:0]             ch;
	logic [`KS_NUM_CH-1:0]  closed;
	logic [`KS_DELAY_W-1:0] ms_left;
	logic [15:0]            tick_cnt;

	logic                   req;
	logic                   skip_ch;
	logic                   released;
	logic                   last_step;
	logic [2:0]             ch_step;

	logic [`KS_DELAY_W-1:0] seq_rdata;
	logic [`KS_DELAY_W-1:0] bus_rdata;
	logic                   acc_wait;
	logic                   acc_ok;
	logic                   acc_done;
	logic [`KS_SLOT_W-1:0]  bus_slot;

	// ------------------------------------------------------------------
	// contact inputs: two-flop synchroniser, closure reads active
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			in_sync1 <= 4'hF;
			in_sync2 <= 4'hF;
		end else begin
			in_sync1 <= {i_jack_two_ring_input_n, i_jack_two_tip_input_n,
				i_jack_one_ring_input_n, i_jack_one_tip_input_n};
			in_sync2 <= in_sync1;
		end
	end

	assign in_active = ~in_sync2;
	assign cw_req    = in_active[0];
	// ptt only keys in the two-sequence configurations
	assign ptt_req   = in_active[1] && (mode != KS_MODE_CW_ONLY);

	// ------------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------------
	always_comb begin
		unique case (ctrl[`KS_CTRL_MODE_HI:`KS_CTRL_MODE_LO])
			2'h1:    mode = KS_MODE_COMBINED;
			2'h2:    mode = KS_MODE_DUAL;
			default: mode = KS_MODE_CW_ONLY;
		endcase
	end

	assign fast_clock_select = ctrl[`KS_CTRL_FAST];
	assign invert            = ctrl[`KS_CTRL_INV_HI:`KS_CTRL_INV_LO];

	// ------------------------------------------------------------------
	// sequence decode
	// ------------------------------------------------------------------
	assign req = seq_ptt ? ptt_req : cw_req;

	always_comb begin
		skip_ch = 1'b0;
		if (mode != KS_MODE_CW_ONLY) begin
			if (!seq_ptt && ch == `KS_CW_SKIP_CH) begin
				skip_ch = 1'b1;
			end
			if (seq_ptt && ch == `KS_PTT_SKIP_CH) begin
				skip_ch = 1'b1;
			end
		end
		if (end_phase) begin
			// channels that never closed cost one clock and no delay on the way down
			skip_ch = !closed[ch];
		end
	end

	// leaving the start sequence early; nothing closed means no end run
	assign released  = !end_phase && !req &&
		(state == KS_LOOK || state == KS_FETCH || state == KS_TIME);
	assign last_step = end_phase ? (ch == `KS_FIRST_CH) :
		(ch == `KS_LAST_CH);
	assign ch_step   = end_phase ? 3'(ch - 3'h1) : 3'(ch + 3'h1);

	// ------------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state     <= KS_IDLE;
			seq_ptt   <= 1'b0;
			end_phase <= 1'b0;
			ch        <= `KS_FIRST_CH;
		end else begin
			unique case (state)
				KS_IDLE: begin
					end_phase <= 1'b0;
					ch        <= `KS_FIRST_CH;
					// cw wins a tie; the other waits for idle
					if (cw_req) begin
						seq_ptt <= 1'b0;
						state   <= KS_LOOK;
					end else if (ptt_req) begin
						seq_ptt <= 1'b1;
						state   <= KS_LOOK;
					end
				end
				KS_LOOK, KS_FETCH, KS_TIME: begin
					if (released) begin
						end_phase <= 1'b1;
						ch        <= `KS_LAST_CH;
						state     <= (closed == '0) ? KS_IDLE : KS_LOOK;
					end else if ((state == KS_LOOK && skip_ch) ||
						(state == KS_TIME && ms_left == '0)) begin
						if (last_step) begin
							state <= end_phase ? KS_IDLE : KS_HOLD;
						end else begin
							ch    <= ch_step;
							state <= KS_LOOK;
						end
					end else if (state == KS_LOOK) begin
						state <= KS_FETCH;
					end else if (state == KS_FETCH) begin
						state <= KS_TIME;
					end
				end
				KS_HOLD: begin
					if (!req) begin
						end_phase <= 1'b1;
						ch        <= `KS_LAST_CH;
						state     <= KS_LOOK;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// millisecond delay count
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ms_left  <= '0;
			tick_cnt <= '0;
		end else if (state == KS_FETCH) begin
			ms_left  <= limit_delay(seq_rdata, fast_clock_select);
			tick_cnt <= TICK_LAST;
		end else if (state == KS_TIME && ms_left != '0) begin
			if (tick_cnt == '0) begin
				tick_cnt <= TICK_LAST;
				ms_left  <= ms_left - 16'h0001;
			end else begin
				tick_cnt <= tick_cnt - 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// channel drive
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			closed <= '0;
		end else if (state == KS_TIME && ms_left == '0 && !released) begin
			closed[ch] <= !end_phase;
		end
	end

	// inversion applies live; a change while keyed flips the pin at once
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_channel_out <= '0;
		end else begin
			o_channel_out <= closed ^ invert;
		end
	end

	// ------------------------------------------------------------------
	// delay table
	// ------------------------------------------------------------------
	assign bus_slot = 5'((i_paddr - `KS_OFF_TABLE) >> 2);

	ks_delay_mem u_delay_mem (
		.i_core_clk  (i_core_clk),
		.i_nrst      (i_nrst),
		.i_wr_en     (acc_done && i_pwrite && in_table(i_paddr)),
		.i_wr_addr   (bus_slot),
		.i_wr_data   (i_pwdata[`KS_DELAY_W-1:0]),
		.i_rd_a_addr (slot_of(seq_ptt && mode == KS_MODE_DUAL,
			end_phase, ch)),
		.o_rd_a_data (seq_rdata),
		.i_rd_b_addr (bus_slot),
		.o_rd_b_data (bus_rdata)
	);

	// ------------------------------------------------------------------
	// apb slave: every transfer takes one wait state
	// ------------------------------------------------------------------
	assign acc_ok   = (i_paddr == `KS_OFF_CTRL) ||
		(i_paddr == `KS_OFF_STATUS) || in_table(i_paddr);
	assign o_pready  = acc_wait;
	assign o_pslverr = acc_wait && !acc_ok;
	assign acc_done  = i_psel && i_penable && acc_wait;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_wait <= 1'b0;
		end else begin
			acc_wait <= i_psel && i_penable && !acc_wait;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl <= `KS_CTRL_RESET;
		end else if (acc_done && i_pwrite && i_paddr == `KS_OFF_CTRL) begin
			ctrl <= '0;
			ctrl[`KS_CTRL_MODE_HI:`KS_CTRL_MODE_LO] <=
				i_pwdata[`KS_CTRL_MODE_HI:`KS_CTRL_MODE_LO];
			ctrl[`KS_CTRL_FAST] <= i_pwdata[`KS_CTRL_FAST];
			ctrl[`KS_CTRL_INV_HI:`KS_CTRL_INV_LO] <=
				i_pwdata[`KS_CTRL_INV_HI:`KS_CTRL_INV_LO];
		end
	end

	// read data captured in the first access cycle, when table data is ready
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_prdata <= '0;
		end else if (i_psel && i_penable && !acc_wait) begin
			o_prdata <= '0;
			if (!i_pwrite) begin
				if (i_paddr == `KS_OFF_CTRL) begin
					o_prdata <= ctrl;
				end else if (i_paddr == `KS_OFF_STATUS) begin
					o_prdata[`KS_ST_OUT_HI:`KS_ST_OUT_LO] <= closed;
					o_prdata[`KS_ST_BUSY] <= (state != KS_IDLE);
					o_prdata[`KS_ST_PTT]  <= seq_ptt;
					o_prdata[`KS_ST_END]  <= end_phase;
					o_prdata[`KS_ST_IN_HI:`KS_ST_IN_LO] <= in_active;
				end else if (in_table(i_paddr)) begin
					o_prdata[`KS_DELAY_W-1:0] <= bus_rdata;
				end
			end
		end
	end

endmodule

// File: test_keying_output_sequencer.sv
/*
 * Self-checking bench for the keying sequencer.
 * Assumes a shortened tick of four clocks per millisecond.
 */
`timescale 1ns/1ps
`include "ks_params.svh"

module test_keying_output_sequencer;
	import ks_pkg::*;
	localparam int TK = 4;
	localparam logic [7:0] TB = `KS_OFF_TABLE;
	localparam logic [7:0] CT = `KS_OFF_CTRL;
	logic        i_core_clk;
	logic        i_nrst;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic [31:0] q;
	logic        o_pready;
	logic        o_pslverr;
	logic        err;
	logic [3:0]  keys;
	logic [4:0]  o_channel_out;
	logic        j1t;
	logic        j1r;
	logic        j2t;
	logic        j2r;
	int          n_mismatch;
	int          comparisons;
	int          t0;
	int          tc;
	int          tp;
	int          t1;

	ks_contact_model i_keys (.i_close(keys), .o_jack_one_tip_input_n(j1t),
		.o_jack_one_ring_input_n(j1r), .o_jack_two_tip_input_n(j2t),
		.o_jack_two_ring_input_n(j2r));
	ks_sequencer #(.TICK_CYCLES(TK)) i_dut (.i_core_clk(i_core_clk),
		.i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
		.i_jack_one_tip_input_n(j1t), .i_jack_one_ring_input_n(j1r),
		.i_jack_two_tip_input_n(j2t), .i_jack_two_ring_input_n(j2r),
		.o_channel_out(o_channel_out));

	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = !i_core_clk;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk_cyc(input string nm, input int e, input int g);
		comparisons++;
		if (g != e) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// one bus transfer; the slave is waited for, never assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_pready !== 1'b1);
		chk_cyc("pready wait", 2, n);
		q = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// change the closures, then count clocks until the channels show e
	task key(input logic [3:0] k, input logic [4:0] e, output int c);
		@(posedge i_core_clk);
		keys <= k;
		c = 0;
		while (o_channel_out !== e && c < 40000) begin
			@(posedge i_core_clk);
			c++;
		end
		chk("channels", {27'h0, e}, {27'h0, o_channel_out});
	endtask

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		comparisons = 0;
		i_nrst = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		keys = 4'h0;
		repeat (8) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		chk("out", 32'h0, {27'h0, o_channel_out});
		apb(1'b0, CT, 32'h0);
		chk("ctrl", `KS_CTRL_RESET, q);
		apb(1'b0, `KS_OFF_TABLE_END, 32'h0);
		chk("slot19", 32'h0, q);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk("err", 32'h1, {31'h0, err});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0000_0000, q);
		apb(1'b1, `KS_OFF_TABLE_END, 32'hFFFF_1234);
		apb(1'b0, `KS_OFF_TABLE_END, 32'h0);
		chk("slot19", 32'h0000_1234, q);
		apb(1'b1, `KS_OFF_TABLE_END, 32'h0);
		$display("registers done");
		key(4'h1, 5'h1F, t0);
		chk_cyc("cw start", 20, t0);
		apb(1'b0, `KS_OFF_STATUS, 32'h0);
		chk("status", 32'h0000_101F, q & 32'h0000_F01F);
		key(4'h0, 5'h00, tc);
		apb(1'b1, TB, 32'h2);
		apb(1'b1, TB + 8'h24, 32'h2);
		key(4'h1, 5'h1F, t1);
		chk_cyc("start delay", t0 + 2 * TK, t1);
		key(4'h0, 5'h00, t1);
		chk_cyc("end delay", tc + 2 * TK, t1);
		apb(1'b1, TB + 8'h24, 32'h0);
		apb(1'b1, TB, 32'h2000);
		key(4'h1, 5'h1F, t1);
		chk_cyc("fast clamp", t0 + 8191 * TK, t1);
		key(4'h0, 5'h00, t1);
		apb(1'b1, CT, 32'h0);
		key(4'h1, 5'h1F, t1);
		chk_cyc("slow delay", t0 + 8192 * TK, t1);
		key(4'h0, 5'h00, t1);
		apb(1'b1, CT, `KS_CTRL_RESET);
		apb(1'b1, TB, 32'h0);
		$display("timing done");
		key(4'h2, 5'h00, t1);
		repeat (40) @(posedge i_core_clk);
		chk("ptt in cw", 32'h0, {27'h0, o_channel_out});
		key(4'hC, 5'h00, t1);
		apb(1'b0, `KS_OFF_STATUS, 32'h0);
		chk("spare inputs", 32'h0000_C000, q & 32'h0000_F1FF);
		key(4'h0, 5'h00, t1);
		apb(1'b1, TB + 8'h08, 32'h5);
		key(4'h1, 5'h03, t1);
		key(4'h0, 5'h00, t1);
		chk_cyc("early release", tc - 3 * 2, t1);
		apb(1'b1, TB + 8'h08, 32'h0);
		$display("early release done");
		apb(1'b1, CT, {29'h0, 1'b1, KS_MODE_COMBINED});
		key(4'h1, 5'h17, tc);
		key(4'h0, 5'h00, t1);
		key(4'h2, 5'h0F, tp);
		key(4'h0, 5'h00, t1);
		key(4'h3, 5'h17, t1);
		key(4'h2, 5'h0F, t1);
		key(4'h0, 5'h00, t1);
		apb(1'b1, CT, {29'h0, 1'b1, KS_MODE_DUAL});
		apb(1'b1, TB + 8'h28, 32'h2);
		key(4'h2, 5'h0F, t1);
		chk_cyc("ptt set", tp + 2 * TK, t1);
		key(4'h0, 5'h00, t1);
		key(4'h1, 5'h17, t1);
		chk_cyc("cw set", tc, t1);
		key(4'h0, 5'h00, t1);
		$display("modes done");
		apb(1'b1, CT, 32'h0000_0104);
		repeat (3) @(posedge i_core_clk);
		chk("inverted idle", 32'h1, {27'h0, o_channel_out});
		key(4'h1, 5'h1E, t1);
		key(4'h0, 5'h01, t1);
		apb(1'b1, CT, `KS_CTRL_RESET);
		$display("inversion done");
		test_done;
	end

	// the tests take about 70000 clocks
	initial begin
		repeat (95000) @(posedge i_core_clk);
		n_mismatch++;
		$display("Error watchdog expected end seen none");
		test_done;
	end
endmodule
